//--- bench/test_pc_stack_status_option.sv
/*
  self-checking bench for the sequencing core: counter, return stack,
  status flags, option register and ratio decode.
  assumes the core takes one decoded instruction per rising edge and
  that rst_i is synchronous; assertions live in the design files.
*/
`timescale 1ns/10ps
module test_pc_stack_status_option;
  import pcsso_pkg::*;
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  pcsso_instr_t instr_i = '0;
  logic watchdog_expiry_flag_i = 1'h1;
  logic sleep_entry_flag_i = 1'h1;
  logic [7:0] read_addr_i = 8'h00;
  logic [8:0] pc_o;
  logic [7:0] w_o, status_o, read_data_o, result_o, timer_div_o, wdt_div_o;
  pcsso_opt_t opt_o;
  logic [5:0] v;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  pcsso_core #(.PC_WIDTH(9)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .watchdog_expiry_flag_i(watchdog_expiry_flag_i), .sleep_entry_flag_i(sleep_entry_flag_i),
    .read_addr_i(read_addr_i), .pc_o(pc_o), .w_o(w_o), .status_o(status_o),
    .read_data_o(read_data_o), .result_o(result_o), .opt_o(opt_o),
    .timer_div_o(timer_div_o), .wdt_div_o(wdt_div_o)
  );

  // 50 MHz instruction-cycle clock
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one instruction per call; outputs settled 1 ns after the edge
  task automatic run(input pcsso_op_t op, input logic [8:0] tg, input logic [7:0] lit,
                     input logic [7:0] f, input logic [7:0] da, input logic we);
    instr_i = '{op: op, target: tg, literal: lit, operand_f: f, dest_addr: da, dest_write: we};
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under 300 cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("pc reset", pc_o, 9'h1FF);
    chk("page bits reset", status_o[7:5], 3'h0);
    chk("flag inputs", status_o[4:3], 2'h3);
    chk("option reset", opt_o, 6'h3F);
    chk("wdt ratio reset", wdt_div_o, 8'h80);
    rst_i = 1'h0;
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("pc wrap", pc_o, 9'h000);
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("pc step", pc_o, 9'h001);
    $display("test reset done");

    // jump, low-byte read and low-byte write clearing bit 8
    run(PCSSO_OP_RETLIT, 9'h000, 8'h34, 8'h00, 8'h10, 1'h0);
    chk("w literal", w_o, 8'h34);
    run(PCSSO_OP_JUMP, 9'h150, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("pc jump", pc_o, 9'h150);
    read_addr_i = 8'h02;
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("pc step", pc_o, 9'h151);
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("pc low read", read_data_o, 8'h51);
    run(PCSSO_OP_MOVE, 9'h000, 8'h00, 8'h34, 8'h02, 1'h1);
    chk("pc low write", pc_o, 9'h034);
    $display("test counter done");

    // three nested calls, then three returns, one more than the two-entry stack holds
    run(PCSSO_OP_JUMP, 9'h020, 8'h00, 8'h00, 8'h10, 1'h0);
    run(PCSSO_OP_CALL, 9'h140, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("call bit8 cleared", pc_o, 9'h040);
    run(PCSSO_OP_CALL, 9'h060, 8'h00, 8'h00, 8'h10, 1'h0);
    run(PCSSO_OP_CALL, 9'h080, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("call target", pc_o, 9'h080);
    run(PCSSO_OP_RETLIT, 9'h000, 8'hA5, 8'h00, 8'h10, 1'h0);
    chk("return one", pc_o, 9'h061);
    chk("return literal", w_o, 8'hA5);
    run(PCSSO_OP_RETLIT, 9'h000, 8'h5A, 8'h00, 8'h10, 1'h0);
    chk("return two", pc_o, 9'h041);
    run(PCSSO_OP_RETLIT, 9'h000, 8'h5A, 8'h00, 8'h10, 1'h0);
    chk("over return", pc_o, 9'h041);
    $display("test stack done");

    // arithmetic flags; w == f keeps the result order-independent
    run(PCSSO_OP_RETLIT, 9'h000, 8'h08, 8'h00, 8'h10, 1'h0);
    run(PCSSO_OP_ADD, 9'h000, 8'h00, 8'h08, 8'h10, 1'h0);
    chk("add nibble carry", status_o[2:0], 3'h2);
    chk("add result", result_o, 8'h10);
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    run(PCSSO_OP_RETLIT, 9'h000, 8'h80, 8'h00, 8'h10, 1'h0);
    run(PCSSO_OP_ADD, 9'h000, 8'h00, 8'h80, 8'h10, 1'h0);
    chk("add carry zero", status_o[2:0], 3'h5);
    run(PCSSO_OP_SUB, 9'h000, 8'h00, 8'h80, 8'h10, 1'h0);
    chk("sub no borrow", status_o[2:0], 3'h7);
    run(PCSSO_OP_RRF, 9'h000, 8'h00, 8'h01, 8'h10, 1'h0);
    chk("rrf carry", status_o[0], 1'h1);
    chk("rrf result", result_o, 8'h80);
    run(PCSSO_OP_RLF, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("rlf carry", status_o[0], 1'h0);
    chk("rlf result", result_o, 8'h01);
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    $display("test flags done");

    // status as destination; w matches f on the move so either source agrees
    watchdog_expiry_flag_i = 1'h0;
    run(PCSSO_OP_RETLIT, 9'h000, 8'hFF, 8'h00, 8'h10, 1'h0);
    run(PCSSO_OP_MOVE, 9'h000, 8'h00, 8'hFF, 8'h03, 1'h1);
    chk("status write", status_o, 8'hEF);
    run(PCSSO_OP_LOGIC, 9'h000, 8'h00, 8'h00, 8'h03, 1'h1);
    chk("flag write blocked", status_o, 8'h0F);
    read_addr_i = 8'h03;
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("status read", read_data_o, 8'h0F);
    watchdog_expiry_flag_i = 1'h1;
    $display("test status done");

    // every ratio code with the watchdog owning the prescaler, codes 0-6 with the timer; timer code 7 saturates at FF and is skipped
    for (int p = 1; p >= 0; p--) begin
      for (int c = 0; c < 8 - (1 - p); c++) begin
        v = {c[0], c[1], p[0], c[2:0]};
        run(PCSSO_OP_RETLIT, 9'h000, {2'h3, v}, 8'h00, 8'h10, 1'h0);
        run(PCSSO_OP_OPTLOAD, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
        chk("option load", opt_o, v);
        run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
        chk("timer ratio", timer_div_o, p ? 16'h1 : (16'h2 << c));
        chk("wdt ratio", wdt_div_o, p ? (16'h1 << c) : 16'h1);
      end
    end
    $display("test option done");

    // reset in mid-run restores counter, option and page bits
    run(PCSSO_OP_MOVE, 9'h000, 8'h00, 8'hFF, 8'h03, 1'h1);
    rst_i = 1'h1;
    run(PCSSO_OP_NONE, 9'h000, 8'h00, 8'h00, 8'h10, 1'h0);
    chk("pc rereset", pc_o, 9'h1FF);
    chk("option rereset", opt_o, 6'h3F);
    chk("page rereset", status_o[7:5], 3'h0);
    rst_i = 1'h0;
    $display("test rereset done");
    complete_run();
  end
endmodule // test_pc_stack_status_option

//--- common/pcsso_pkg.sv
/*
  package for the sequencing core: status/option layouts, reset values,
  instruction-class encodings and the decoded-instruction carrier.
  assumes an external decoder classifies each executing instruction.
*/
package pcsso_pkg;
  localparam int PC_W = 9;
  localparam int OPT_W = 6;
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam logic [7:0] PCL_ADDR = 8'h02;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_PAL = 5;
  localparam int ST_PAM = 6;
  localparam int ST_PAH = 7;
  // option bit positions
  localparam int OPT_SRC = 5;
  localparam int OPT_EDGE = 4;
  localparam int OPT_ASSIGN = 3;
  localparam logic [OPT_W-1:0] OPT_RESET = 6'h3F;
  localparam logic [PC_W-1:0] PC_RESET = 9'h1FF;
  localparam logic [PC_W-1:0] PC_WRAP = 9'h000;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [7:0] PRE_MAX = 8'hFF;

  typedef enum logic [3:0] {
    PCSSO_OP_NONE,
    PCSSO_OP_JUMP,
    PCSSO_OP_CALL,
    PCSSO_OP_RETLIT,
    PCSSO_OP_OPTLOAD,
    PCSSO_OP_ADD,
    PCSSO_OP_SUB,
    PCSSO_OP_RRF,
    PCSSO_OP_RLF,
    PCSSO_OP_LOGIC,
    PCSSO_OP_MOVE
  } pcsso_op_t;

  // one executing instruction as presented by the decoder
  typedef struct packed {
    pcsso_op_t op;
    logic [8:0] target;
    logic [7:0] literal;
    logic [7:0] operand_f;
    logic [7:0] dest_addr;
    logic dest_write;
  } pcsso_instr_t;

  typedef struct packed {
    logic timer_source_select;
    logic timer_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
  } pcsso_opt_t;
endpackage

//--- logic/pcsso_alu_flags.sv
/*
  flag generator for add, subtract and rotates.
  assumes operands are presented combinationally by the core.
*/
`timescale 1ns/10ps
module pcsso_alu_flags (
  input wire pcsso_pkg::pcsso_op_t op_i,
  input wire logic [7:0] w_i,
  input wire logic [7:0] f_i,
  input wire logic carry_in_i,
  output logic [7:0] result_o,
  output logic carry_o,
  output logic nibble_o
);
  import pcsso_pkg::*;
  logic [8:0] add_sum;
  logic [8:0] sub_sum;
  logic [4:0] add_nib;
  logic [4:0] sub_nib;

  // subtract is f + ~w + 1, so carry out means no borrow
  assign add_sum = {1'b0, f_i} + {1'b0, w_i};
  assign sub_sum = {1'b0, f_i} + {1'b0, ~w_i} + 9'h001;
  assign add_nib = {1'b0, f_i[3:0]} + {1'b0, w_i[3:0]};
  assign sub_nib = {1'b0, f_i[3:0]} + {1'b0, ~w_i[3:0]} + 5'h01;

  always_comb begin
    result_o = f_i;
    carry_o = carry_in_i;
    nibble_o = 1'b0;
    case (op_i)
      PCSSO_OP_ADD: begin
        result_o = add_sum[7:0];
        carry_o = add_sum[8];
        nibble_o = add_nib[4];
      end
      PCSSO_OP_SUB: begin
        result_o = sub_sum[7:0];
        carry_o = sub_sum[8];
        nibble_o = sub_nib[4];
      end
      PCSSO_OP_RRF: begin
        result_o = {carry_in_i, f_i[7:1]};
        carry_o = f_i[0];
      end
      PCSSO_OP_RLF: begin
        result_o = {f_i[6:0], carry_in_i};
        carry_o = f_i[7];
      end
      default: begin
        result_o = f_i;
      end
    endcase
  end
endmodule // pcsso_alu_flags

//--- logic/pcsso_core.sv
/*
  sequencing core: program counter, return stack, status and option
  registers, prescaler ratio decode.
  assumes sys_clk_i is the instruction-cycle clock and that an external
  decoder presents one executing instruction per cycle; rst_i merges
  power-on, external and watchdog resets.
*/
`timescale 1ns/10ps
module pcsso_core #(
  parameter int PC_WIDTH = 9
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire pcsso_pkg::pcsso_instr_t instr_i,
  input wire logic watchdog_expiry_flag_i,
  input wire logic sleep_entry_flag_i,
  input wire logic [7:0] read_addr_i,
  output logic [PC_WIDTH-1:0] pc_o,
  output logic [7:0] w_o,
  output logic [7:0] status_o,
  output logic [7:0] read_data_o,
  output logic [7:0] result_o,
  output pcsso_pkg::pcsso_opt_t opt_o,
  output logic [7:0] timer_div_o,
  output logic [7:0] wdt_div_o
);
  import pcsso_pkg::*;

  logic [PC_WIDTH-1:0] pc;
  logic [7:0] w_reg;
  logic [7:0] status;
  logic [OPT_W-1:0] opt_reg;
  logic [7:0] next_result;
  logic [PC_WIDTH-1:0] next_pc;
  logic [PC_WIDTH-1:0] pc_inc;
  logic [PC_WIDTH-1:0] stack_top;
  logic [7:0] next_status;
  logic [7:0] next_read;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_nibble;
  logic is_call;
  logic is_ret;
  logic is_jump;
  logic sets_flags;
  logic sets_zero;
  logic pcl_write;
  logic status_write;

  // power-of-two divider, shift bounded to the 8-bit output
  function automatic logic [7:0] pow2(input logic [3:0] n);
    pow2 = (n > 4'h7) ? PRE_MAX : (8'h01 << n);
  endfunction

  // instruction class decode
  assign is_call = instr_i.op == PCSSO_OP_CALL;
  assign is_ret = instr_i.op == PCSSO_OP_RETLIT;
  assign is_jump = instr_i.op == PCSSO_OP_JUMP;
  assign sets_flags = instr_i.op inside {PCSSO_OP_ADD, PCSSO_OP_SUB, PCSSO_OP_RRF, PCSSO_OP_RLF};
  assign sets_zero = instr_i.op inside {PCSSO_OP_ADD, PCSSO_OP_SUB, PCSSO_OP_LOGIC};
  assign pcl_write = instr_i.dest_write && instr_i.dest_addr == PCL_ADDR;
  assign status_write = instr_i.dest_write && instr_i.dest_addr == STATUS_ADDR;

  pcsso_alu_flags u_alu (
    .op_i(instr_i.op),
    .w_i(w_reg),
    .f_i(instr_i.operand_f),
    .carry_in_i(status[ST_C]),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .nibble_o(alu_nibble)
  );

  // logic ops hand their result in through operand_f
  assign next_result = alu_result;

  // counter increment wraps naturally at nine bits
  assign pc_inc = pc + PC_WIDTH'(1);

  pcsso_stack #(
    .W(PC_WIDTH)
  ) u_stack (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .push_i(is_call),
    .pop_i(is_ret),
    .push_addr_i(pc_inc),
    .top_o(stack_top)
  );

  // next counter selection, priority: jump, call, return, low-byte write
  assign next_pc = is_jump ? instr_i.target :
                   is_call ? {1'b0, instr_i.target[7:0]} :
                   is_ret ? stack_top :
                   pcl_write ? {1'b0, next_result} :
                   pc_inc;

  // status next value; flags from instruction win over destination write
  always_comb begin
    next_status = status;
    if (status_write) begin
      next_status[ST_PAH] = next_result[ST_PAH];
      next_status[ST_PAM] = next_result[ST_PAM];
      next_status[ST_PAL] = next_result[ST_PAL];
      if (!sets_flags && !sets_zero) begin
        next_status[2:0] = next_result[2:0];
      end
    end
    if (sets_zero) begin
      next_status[ST_Z] = next_result == 8'h00;
    end
    if (sets_flags) begin
      next_status[ST_C] = alu_carry;
      next_status[ST_DC] = alu_nibble;
    end
    next_status[ST_TO] = watchdog_expiry_flag_i;
    next_status[ST_PD] = sleep_entry_flag_i;
  end

  // read mux; option register deliberately absent from it
  assign next_read = (read_addr_i == PCL_ADDR) ? pc[7:0] :
                     (read_addr_i == STATUS_ADDR) ? next_status :
                     8'h00;

  // program counter
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // status register; page bits and C, DC, Z clear on reset, TO and PD set
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status <= {PAGE_RESET, 5'h18};
    end else begin
      status <= next_status;
    end
  end

  // working register: return loads its literal
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      w_reg <= 8'h00;
    end else if (is_ret) begin
      w_reg <= instr_i.literal;
    end else if (instr_i.op == PCSSO_OP_MOVE && !instr_i.dest_write) begin
      w_reg <= next_result;
    end
  end

  // option register, write-only from software
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      opt_reg <= OPT_RESET;
    end else if (instr_i.op == PCSSO_OP_OPTLOAD) begin
      opt_reg <= w_reg[OPT_W-1:0];
    end
  end

  // option fields feeding the ratio decode, declared before the output process reads them
  logic next_opt_assign;
  logic [2:0] next_ratio;
  assign next_opt_assign = opt_reg[OPT_ASSIGN];
  assign next_ratio = opt_reg[2:0];

  // registered outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      read_data_o <= 8'h00;
      result_o <= 8'h00;
      timer_div_o <= 8'h80;
      wdt_div_o <= 8'h80;
    end else begin
      read_data_o <= next_read;
      result_o <= next_result;
      // prescaler only divides the side it is assigned to
      timer_div_o <= next_opt_assign ? 8'h01 : pow2({1'b0, next_ratio} + 4'h1);
      wdt_div_o <= next_opt_assign ? pow2({1'b0, next_ratio}) : 8'h01;
    end
  end

  assign pc_o = pc;
  assign w_o = w_reg;
  assign status_o = status;
  // field view of the option bits for timer logic
  assign opt_o = '{timer_source_select: opt_reg[OPT_SRC],
                   timer_edge_select: opt_reg[OPT_EDGE],
                   prescaler_assign: opt_reg[OPT_ASSIGN],
                   prescale_ratio: opt_reg[2:0]};

  // named sequences for call then return
  sequence s_call;
    is_call;
  endsequence

  sequence s_ret_next;
    is_ret;
  endsequence

  a_pc_advance: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    instr_i.op == PCSSO_OP_NONE && !pcl_write |=> pc == $past(pc) + PC_WIDTH'(1))
    else $error("counter did not advance");
  a_jump_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    is_jump |=> pc == $past(instr_i.target))
    else $error("jump target not loaded");
  a_call_page: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    is_call |=> pc[8] == 1'b0 && pc[7:0] == $past(instr_i.target[7:0]))
    else $error("call did not clear bit 8");
  a_call_return: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_call ##1 s_ret_next |=> pc == $past(pc, 2) + PC_WIDTH'(1))
    else $error("return address wrong");
  a_ret_literal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    is_ret |=> w_reg == $past(instr_i.literal))
    else $error("literal not loaded");
  a_reset_pc: assert property (@(posedge sys_clk_i)
    rst_i |=> pc == PC_RESET && status[7:5] == PAGE_RESET && opt_reg == OPT_RESET)
    else $error("reset values wrong");
  a_wrap_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pc == PC_RESET && instr_i.op == PCSSO_OP_NONE && !pcl_write |=> pc == PC_WRAP)
    else $error("counter did not wrap");
  a_opt_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    instr_i.op == PCSSO_OP_OPTLOAD |=> opt_reg == $past(w_reg[OPT_W-1:0]))
    else $error("option load failed");
  a_flag_guard: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    status_write && sets_zero |=> status[ST_Z] == ($past(next_result) == 8'h00))
    else $error("zero flag overwritten");
  a_read_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    read_addr_i == PCL_ADDR |=> read_data_o == $past(pc[7:0]))
    else $error("low byte read wrong");
  a_flags_locked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> status[ST_TO] == $past(watchdog_expiry_flag_i) && status[ST_PD] == $past(sleep_entry_flag_i))
    else $error("reset flags were written");
endmodule // pcsso_core

//--- logic/pcsso_stack.sv
/*
  two-entry return stack, nine bits per entry.
  assumes push and pop are never requested in the same cycle.
*/
`timescale 1ns/10ps
module pcsso_stack #(
  parameter int W = 9
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [W-1:0] push_addr_i,
  output logic [W-1:0] top_o
);
  logic [W-1:0] level [2];

  // entry two is left unchanged by a pop, so over-popping repeats it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      level[0] <= '0;
      level[1] <= '0;
    end else if (push_i) begin
      level[1] <= level[0];
      level[0] <= push_addr_i;
    end else if (pop_i) begin
      level[0] <= level[1];
    end
  end

  assign top_o = level[0];

  a_push_shift: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    push_i |=> level[1] == $past(level[0]) && level[0] == $past(push_addr_i))
    else $error("push did not shift stack");
  a_pop_keep: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pop_i && !push_i |=> level[0] == $past(level[1]) && $stable(level[1]))
    else $error("pop did not copy level two");
endmodule // pcsso_stack
